// [hdl/inrush_params.svh]
// Timing, range and default constants for the inrush blocking controller
`ifndef INRUSH_PARAMS_SVH
`define INRUSH_PARAMS_SVH

// -----------------------------------------------------------------
// Time base
// -----------------------------------------------------------------
`define IR_SECOND_NS     1000000000
`define IR_CLK_PERIOD_NS 100
`define IR_SEC_CYCLES    (`IR_SECOND_NS / `IR_CLK_PERIOD_NS)
`define IR_SEC_LAST      6'h3B
`define IR_PRESC_W       24

// -----------------------------------------------------------------
// Setting ranges and defaults
// -----------------------------------------------------------------
`define IR_TIME_MIN       10'h001
`define IR_TIME_MAX       10'h3E8
`define IR_OUTAGE_DEFAULT 10'h064
`define IR_BLOCK_DEFAULT  10'h005
`define IR_PCT_MAX        7'h64
`define IR_PCT_BASE       8'h64
`define IR_GROUP_ACTIVE   3'h0
`define IR_GROUP_LAST     3'h4
`define IR_TIMER_ONE      11'h001

`endif

// [hdl/inrush_pkg.sv]
// Types shared by the inrush blocking controller and its pickup scaler
package inrush_pkg;

	typedef enum logic [1:0]
	{
		FN_DISABLED = 2'h0,
		FN_ALARM    = 2'h1,
		FN_LATCHED  = 2'h2,
		FN_CONTROL  = 2'h3
	} function_t;

	typedef enum logic [3:0]
	{
		CL_IDLE    = 4'h1,
		CL_OUTAGE  = 4'h2,
		CL_COLD    = 4'h4,
		CL_RESTORE = 4'h8
	} cl_state_t;

	// Element order: phase, neutral, ground, sensitive earth, negative sequence
	typedef struct packed
	{
		function_t       fn;
		logic [4:0]      relays;        // bit 0 is auxiliary relay 3
		logic [9:0]      block_time;    // seconds
		logic [4:0]      inst_block_en;
		logic [4:0][6:0] raise_pct;
		logic [2:0]      group_sel;     // 0 keeps active group, 1..4 group
	} scheme_cfg_t;

	typedef struct packed
	{
		logic [2:0] low;    // phase below 5 percent of nominal
		logic [2:0] high;   // phase above 10 percent of nominal
	} phase_level_t;

	typedef struct packed
	{
		logic [16:0] pickup;
	} scale_state_t;

	typedef struct packed
	{
		logic [1:0]      sync1;
		logic [1:0]      sync2;
		logic            mc_prev;
		logic [23:0]     presc;
		logic            tick;
		cl_state_t       cl_state;
		logic [5:0]      out_sec;
		logic [9:0]      out_min;
		logic [10:0]     cl_sec;
		logic [10:0]     mc_sec;
		logic [1:0]      latch;
		logic [4:0]      inst_block;
		logic [1:0]      group;
		logic [4:0]      relays;
		logic            alarm;
		logic            mc_blk;
		logic            cl_on;
		logic [4:0][6:0] raise;
	} core_state_t;

endpackage

// [hdl/pickup_scale.sv]
// Raised pickup level for one time overcurrent element
`timescale 1ns/1ps
`include "inrush_params.svh"

module pickup_scale
(
	input  wire logic        clock_in,    // System clock
	input  wire logic        rstn_in,     // Synchronous reset, active low
	input  wire logic [15:0] base_in,     // Base pickup level
	input  wire logic [6:0]  raise_in,    // Raise percentage, 0 to 100
	output logic      [16:0] pickup_out   // Effective pickup level
);

	inrush_pkg::scale_state_t q;
	inrush_pkg::scale_state_t d;
	logic [7:0]               factor;
	logic [23:0]              product;
	logic [23:0]              quotient;

	always_comb
	begin
		factor   = `IR_PCT_BASE + {1'b0, raise_in};
		product  = {8'h00, base_in} * {16'h0000, factor};
		quotient = product / {16'h0000, `IR_PCT_BASE};
		d        = q;
		d.pickup = quotient[16:0];
	end

	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
			q <= '0;
		else
			q <= d;
	end

	assign pickup_out = q.pickup;

	a_unity_scale: assert property (@(posedge clock_in) disable iff (!rstn_in)
		raise_in == 7'h00 |=> pickup_out == {1'b0, $past(base_in)})
		else $error("pickup changed with zero raise");

endmodule

// [hdl/inrush_block.sv]
// Manual close and cold load blocking of overcurrent elements
`timescale 1ns/1ps
`include "inrush_params.svh"

module inrush_block
#(
	parameter logic [23:0] SEC_CYCLES = 24'(`IR_SEC_CYCLES)
)
(
	input  wire logic                     clock_in,               // System clock
	input  wire logic                     rstn_in,                // Sync reset, low
	input  wire logic                     manual_close_pin_in,    // Manual close input
	input  wire logic                     cold_load_pin_in,       // Cold load logic input
	input  wire logic                     alarm_reset_in,         // Clears latched alarm
	input  wire inrush_pkg::phase_level_t phase_level_in,         // Current comparisons
	input  wire inrush_pkg::scheme_cfg_t  mc_cfg_in,              // Manual close setup
	input  wire inrush_pkg::scheme_cfg_t  cl_cfg_in,              // Cold load setup
	input  wire logic [9:0]               outage_delay_setting_in, // Minutes
	input  wire logic [1:0]               active_group_in,        // Current group
	input  wire logic [4:0][15:0]         base_pickup_in,         // Time OC pickups
	output logic      [4:0]               inst_block_out,         // Instant OC inhibit
	output logic      [4:0][16:0]         pickup_out,             // Effective pickups
	output logic      [1:0]               group_out,              // Group to use
	output logic      [4:0]               aux_relay_out,          // Relays 3..7
	output logic                          alarm_out,              // Alarm indication
	output logic                          mc_blocking_out,        // Manual close blocking
	output logic                          cold_load_out           // Cold load active
);

	// -----------------------------------------------------------------
	// Decoding helpers
	// -----------------------------------------------------------------
	function automatic logic blocks(inrush_pkg::function_t fn, logic act);
		return act && (fn == inrush_pkg::FN_CONTROL);
	endfunction

	function automatic logic [9:0] sane_time(logic [9:0] v, logic [9:0] dflt);
		return (v < `IR_TIME_MIN || v > `IR_TIME_MAX) ? dflt : v;
	endfunction

	function automatic logic [6:0] sane_pct(logic [6:0] v);
		return (v > `IR_PCT_MAX) ? `IR_PCT_MAX : v;
	endfunction

	function automatic logic group_valid(logic [2:0] sel);
		return (sel != `IR_GROUP_ACTIVE) && (sel <= `IR_GROUP_LAST);
	endfunction

	inrush_pkg::core_state_t q;
	inrush_pkg::core_state_t d;
	logic                    all_low;
	logic                    any_high;
	logic                    mc_edge;
	logic                    force_cold;
	logic                    mc_act;
	logic                    cl_act;
	logic                    mc_blk;
	logic                    cl_blk;
	logic [9:0]              delay_min;
	logic [6:0]              mc_pct;
	logic [6:0]              cl_pct;

	// -----------------------------------------------------------------
	// Next state
	// -----------------------------------------------------------------
	always_comb
	begin
		d         = q;
		all_low   = &phase_level_in.low;
		any_high  = |phase_level_in.high;
		mc_edge   = q.sync2[0] && !q.mc_prev;
		force_cold = q.sync2[1];
		delay_min = sane_time(outage_delay_setting_in, `IR_OUTAGE_DEFAULT);
		mc_act    = q.mc_sec != 11'h000;
		cl_act    = (q.cl_state == inrush_pkg::CL_COLD) || (q.cl_state == inrush_pkg::CL_RESTORE);
		mc_blk    = blocks(mc_cfg_in.fn, mc_act);
		cl_blk    = blocks(cl_cfg_in.fn, cl_act);
		mc_pct    = 7'h00;
		cl_pct    = 7'h00;

		d.sync1   = {cold_load_pin_in, manual_close_pin_in};
		d.sync2   = q.sync1;
		d.mc_prev = q.sync2[0];

		// Shared prescaler: a timer may lose up to one second, so timers load one extra
		if (q.presc >= SEC_CYCLES - 24'h000001)
		begin
			d.presc = '0;
			d.tick  = 1'b1;
		end
		else
		begin
			d.presc = q.presc + 24'h000001;
			d.tick  = 1'b0;
		end

		if (mc_cfg_in.fn == inrush_pkg::FN_DISABLED)
			d.mc_sec = '0;
		else if (mc_edge)
			d.mc_sec = {1'b0, sane_time(mc_cfg_in.block_time, `IR_BLOCK_DEFAULT)} + `IR_TIMER_ONE;
		else if (q.tick && mc_act)
			d.mc_sec = q.mc_sec - `IR_TIMER_ONE;

		case (q.cl_state)
			inrush_pkg::CL_IDLE:
			begin
				if (all_low)
				begin
					d.cl_state = inrush_pkg::CL_OUTAGE;
					d.out_sec  = '0;
					d.out_min  = '0;
				end
			end
			inrush_pkg::CL_OUTAGE:
			begin
				if (!all_low)
					d.cl_state = inrush_pkg::CL_IDLE;
				else if (q.tick)
				begin
					if (q.out_min == delay_min)
						d.cl_state = inrush_pkg::CL_COLD;
					else if (q.out_sec == `IR_SEC_LAST)
					begin
						d.out_sec = '0;
						d.out_min = q.out_min + 10'h001;
					end
					else
						d.out_sec = q.out_sec + 6'h01;
				end
			end
			inrush_pkg::CL_COLD:
			begin
				if (any_high)
				begin
					d.cl_state = inrush_pkg::CL_RESTORE;
					d.cl_sec   = {1'b0, sane_time(cl_cfg_in.block_time, `IR_BLOCK_DEFAULT)}
						+ `IR_TIMER_ONE;
				end
			end
			inrush_pkg::CL_RESTORE:
			begin
				if (q.tick)
				begin
					d.cl_sec = q.cl_sec - `IR_TIMER_ONE;
					if (q.cl_sec <= `IR_TIMER_ONE)
						d.cl_state = inrush_pkg::CL_IDLE;
				end
			end
			default:
			begin
				d.cl_state = inrush_pkg::CL_IDLE;
			end
		endcase

		if (force_cold)
			d.cl_state = inrush_pkg::CL_COLD;
		if (cl_cfg_in.fn == inrush_pkg::FN_DISABLED)
		begin
			d.cl_state = inrush_pkg::CL_IDLE;
			d.cl_sec   = '0;
		end

		// Union of both schemes' enables
		d.inst_block = (mc_blk ? mc_cfg_in.inst_block_en : 5'h00)
			| (cl_blk ? cl_cfg_in.inst_block_en : 5'h00);
		for (int i = 0; i < 5; i++)
		begin
			mc_pct     = mc_blk ? sane_pct(mc_cfg_in.raise_pct[i]) : 7'h00;
			cl_pct     = cl_blk ? sane_pct(cl_cfg_in.raise_pct[i]) : 7'h00;
			d.raise[i] = (mc_pct > cl_pct) ? mc_pct : cl_pct;
		end

		// Manual close group wins when both pick one
		if (mc_blk && group_valid(mc_cfg_in.group_sel))
			d.group = 2'(mc_cfg_in.group_sel - 3'h1);
		else if (cl_blk && group_valid(cl_cfg_in.group_sel))
			d.group = 2'(cl_cfg_in.group_sel - 3'h1);
		else
			d.group = active_group_in;

		d.relays = ((mc_act && mc_cfg_in.fn != inrush_pkg::FN_DISABLED) ? mc_cfg_in.relays : 5'h00)
			| ((cl_act && cl_cfg_in.fn != inrush_pkg::FN_DISABLED) ? cl_cfg_in.relays : 5'h00);

		// Set beats reset request in the same cycle
		d.latch[0] = (mc_act && mc_cfg_in.fn == inrush_pkg::FN_LATCHED)
			|| (q.latch[0] && !alarm_reset_in);
		d.latch[1] = (cl_act && cl_cfg_in.fn == inrush_pkg::FN_LATCHED)
			|| (q.latch[1] && !alarm_reset_in);
		d.alarm = (|d.latch) || (mc_act && mc_cfg_in.fn == inrush_pkg::FN_ALARM)
			|| (cl_act && cl_cfg_in.fn == inrush_pkg::FN_ALARM);

		d.mc_blk = mc_blk;
		d.cl_on  = cl_act;
	end

	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
		begin
			q          <= '0;
			q.cl_state <= inrush_pkg::CL_IDLE;
		end
		else
			q <= d;
	end

	// -----------------------------------------------------------------
	// Pickup scaling per time element
	// -----------------------------------------------------------------
	generate
		for (genvar g = 0; g < 5; g++)
		begin : g_scale
			pickup_scale u_scale
			(
				.clock_in   (clock_in),
				.rstn_in    (rstn_in),
				.base_in    (base_pickup_in[g]),
				.raise_in   (q.raise[g]),
				.pickup_out (pickup_out[g])
			);
		end
	endgenerate

	assign inst_block_out  = q.inst_block;
	assign group_out       = q.group;
	assign aux_relay_out   = q.relays;
	assign alarm_out       = q.alarm;
	assign mc_blocking_out = q.mc_blk;
	assign cold_load_out   = q.cl_on;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rstn_in);

	a_disabled_no_cold: assert property (
		cl_cfg_in.fn == inrush_pkg::FN_DISABLED [*3] |-> !cold_load_out)
		else $error("cold load active while disabled");

	a_force_starts_cold: assert property (
		force_cold && cl_cfg_in.fn != inrush_pkg::FN_DISABLED |=> q.cl_state == inrush_pkg::CL_COLD)
		else $error("cold load input did not start cold load");

	a_outage_abort: assert property (
		q.cl_state == inrush_pkg::CL_OUTAGE && !all_low && !force_cold
		&& cl_cfg_in.fn != inrush_pkg::FN_DISABLED |=> q.cl_state == inrush_pkg::CL_IDLE)
		else $error("outage kept running with current present");

	a_cold_holds: assert property (
		q.cl_state == inrush_pkg::CL_COLD && !any_high
		&& cl_cfg_in.fn != inrush_pkg::FN_DISABLED |=> q.cl_state == inrush_pkg::CL_COLD)
		else $error("cold load left without current return");

	a_restore_timer: assert property (
		q.cl_state == inrush_pkg::CL_RESTORE && !(q.tick && q.cl_sec == `IR_TIMER_ONE)
		&& !force_cold && cl_cfg_in.fn != inrush_pkg::FN_DISABLED
		|=> q.cl_state == inrush_pkg::CL_RESTORE)
		else $error("block period ended early");

	a_mc_starts_block: assert property (
		mc_edge && mc_cfg_in.fn == inrush_pkg::FN_CONTROL ##1 mc_cfg_in.fn == inrush_pkg::FN_CONTROL
		|=> mc_blocking_out)
		else $error("manual close did not block");

	a_mc_union: assert property (
		mc_blk |=> (inst_block_out & $past(mc_cfg_in.inst_block_en)) == $past(mc_cfg_in.inst_block_en))
		else $error("enabled instant element not blocked");

	a_idle_normal: assert property (
		!mc_blk && !cl_blk |=> inst_block_out == 5'h00 && group_out == $past(active_group_in)
		&& q.raise == '0)
		else $error("settings altered without blocking");

	a_relays_quiet: assert property (
		!mc_act && !cl_act |=> aux_relay_out == 5'h00)
		else $error("relays driven while inactive");

endmodule

// [bench/feeder_model.sv]
// Behavioural feeder currents and breaker close contact
`timescale 1ns/1ps

module feeder_model
(
	input  wire logic               clock_in,        // System clock
	input  wire logic [1:0]         load_in,         // 0 dead,1 one live,2 all live,3 mid
	input  wire logic [1:0]         phase_sel_in,    // Phase restored first
	input  wire logic               close_req_in,    // Close command
	output inrush_pkg::phase_level_t phase_level_out, // Current comparisons
	output logic                    close_pin_out    // Manual close contact
);
	logic [2:0] close_cnt_q = 3'h0;

	// -----------------------------------------
	// Comparators update just after the edge
	// -----------------------------------------
	always @(posedge clock_in)
	begin
		case (load_in)
			2'h0: phase_level_out <= '{low: 3'h7, high: 3'h0};
			2'h1: phase_level_out <= '{low: ~(3'h1 << phase_sel_in), high: 3'h1 << phase_sel_in};
			2'h2: phase_level_out <= '{low: 3'h0, high: 3'h7};
			default: phase_level_out <= '{low: 3'h0, high: 3'h0};
		endcase
		// Contact bounces shut for 4 cycles so the synchroniser catches it
		if (close_req_in)
			close_cnt_q <= 3'h4;
		else if (close_cnt_q != 3'h0)
			close_cnt_q <= close_cnt_q - 3'h1;
	end

	assign close_pin_out = (close_cnt_q != 3'h0);
endmodule

// [bench/tb_inrush_block.sv]
// Self-checking bench for the inrush blocking controller
`timescale 1ns/1ps

module tb_inrush_block;
	logic                     clock_in = 1'b0;
	logic                     rstn_in = 1'b0;
	logic                     cold_pin = 1'b0;
	logic                     alarm_reset = 1'b0;
	logic                     close_req = 1'b0;
	logic                     close_pin;
	logic [1:0]               load = 2'h2;
	logic [1:0]               phase_sel = 2'h0;
	inrush_pkg::phase_level_t levels;
	inrush_pkg::scheme_cfg_t  mc_cfg = '0;
	inrush_pkg::scheme_cfg_t  cl_cfg = '0;
	logic [9:0]               outage = 10'h001;
	logic [1:0]               active_group = 2'h0;
	logic [4:0][15:0]         base = '0;
	logic [4:0][6:0]          mx;
	logic [4:0]               inst_block;
	logic [4:0][16:0]         pickup;
	logic [1:0]               group;
	logic [4:0]               relays;
	logic                     alarm;
	logic                     mc_blocking;
	logic                     cold_load;
	int                       mismatches = 0;
	int                       n_compared = 0;
	int                       n;

	always #50 clock_in = ~clock_in;

	feeder_model i_feeder_model (.clock_in(clock_in), .load_in(load), .phase_sel_in(phase_sel),
		.close_req_in(close_req), .phase_level_out(levels), .close_pin_out(close_pin));

	// One second is ten cycles, one minute six hundred
	inrush_block #(.SEC_CYCLES(24'h00000A)) i_inrush_block (.clock_in(clock_in),
		.rstn_in(rstn_in), .manual_close_pin_in(close_pin), .cold_load_pin_in(cold_pin),
		.alarm_reset_in(alarm_reset), .phase_level_in(levels), .mc_cfg_in(mc_cfg),
		.cl_cfg_in(cl_cfg), .outage_delay_setting_in(outage), .active_group_in(active_group),
		.base_pickup_in(base), .inst_block_out(inst_block), .pickup_out(pickup),
		.group_out(group), .aux_relay_out(relays), .alarm_out(alarm),
		.mc_blocking_out(mc_blocking), .cold_load_out(cold_load));

	// -----------------------------------------
	// Helpers
	// -----------------------------------------
	task automatic step(input int k);
		repeat (k) @(posedge clock_in);
		#10;
	endtask

	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	// Bounded wait; the caller compares the level afterwards
	task automatic wait_lvl(ref logic s, input logic v, input int lim, output int k);
		k = 0;
		while (s !== v && k < lim)
		begin
			step(1);
			k++;
		end
	endtask

	task automatic stop_test();
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	function automatic logic [84:0] exp_pick(input logic [4:0][6:0] r);
		logic [84:0] v;
		for (int i = 0; i < 5; i++)
			v[i*17 +: 17] = 17'((32'(base[i]) * (32'h64 + 32'(r[i] > 7'h64 ? 7'h64 : r[i])))
				/ 32'h64);
		return v;
	endfunction

	function automatic logic [1:0] exp_group(input logic [2:0] sel);
		return (sel >= 3'h1 && sel <= 3'h4) ? 2'(sel - 3'h1) : active_group;
	endfunction

	task automatic rand_cfg(output inrush_pkg::scheme_cfg_t c, input int f, input logic [9:0] t);
		c.fn = inrush_pkg::function_t'(f);
		c.relays = 5'($urandom);
		c.block_time = t;
		c.inst_block_en = 5'($urandom);
		for (int i = 0; i < 5; i++)
			c.raise_pct[i] = 7'($urandom_range(100));
		c.raise_pct[0] = 7'h64;
		// Element 4 also draws refused values above 100, which must clamp
		c.raise_pct[4] = 7'($urandom_range(127));
		c.group_sel = 3'($urandom_range(4));
	endtask

	// -----------------------------------------
	// Watchdog
	// -----------------------------------------
	initial
	begin
		#(20000 * 100);
		mismatches++;
		stop_test();
	end

	initial
	begin
		void'($urandom(28082));
		base = 80'({$urandom, $urandom, $urandom});
		active_group = 2'($urandom);
		step(12);
		check({inst_block, group, relays, alarm, mc_blocking, cold_load}, 0);
		rstn_in = 1'b1;
		step(4);
		check(pickup, exp_pick('0));
		// Manual close, every group choice
		for (int g = 0; g < 6; g++)
		begin
			rand_cfg(mc_cfg, 3, 10'h001);
			mc_cfg.group_sel = 3'(g);
			close_req = 1'b1;
			step(1);
			close_req = 1'b0;
			wait_lvl(mc_blocking, 1'b1, 10, n);
			check(mc_blocking, 1'b1);
			check(inst_block, mc_cfg.inst_block_en);
			check(group, exp_group(mc_cfg.group_sel));
			check(relays, mc_cfg.relays);
			step(2);
			check(pickup, exp_pick(mc_cfg.raise_pct));
			wait_lvl(mc_blocking, 1'b0, 40, n);
			check(n + 2 >= 10 && n + 2 <= 20, 1'b1);
			step(2);
			check(pickup, exp_pick('0));
		end
		mc_cfg.fn = inrush_pkg::FN_DISABLED;
		close_req = 1'b1;
		step(1);
		close_req = 1'b0;
		step(8);
		check({mc_blocking, relays, inst_block}, 0);
		// Alarm mode with a refused time: default period, no blocking
		rand_cfg(mc_cfg, 1, 10'h000);
		close_req = 1'b1;
		step(1);
		close_req = 1'b0;
		wait_lvl(alarm, 1'b1, 10, n);
		check({alarm, mc_blocking, inst_block, relays}, {1'b1, 1'b0, 5'h00, mc_cfg.relays});
		wait_lvl(alarm, 1'b0, 80, n);
		check(n >= 50 && n <= 60, 1'b1);
		// Forced cold load in each mode
		for (int f = 0; f < 4; f++)
		begin
			rand_cfg(cl_cfg, f, 10'h001);
			cold_pin = 1'b1;
			wait_lvl(cold_load, 1'b1, 8, n);
			step(1);
			check(cold_load, f != 0);
			check(relays, f != 0 ? cl_cfg.relays : 5'h0);
			check(inst_block, f == 3 ? cl_cfg.inst_block_en : 5'h0);
			if (f < 3)
				check(alarm, f != 0);
			cold_pin = 1'b0;
			// Let the synchroniser flush before the pin can rise again
			step(3);
			wait_lvl(cold_load, 1'b0, 40, n);
			if (f != 0)
				check(n >= 9 && n <= 25, 1'b1);
			if (f == 2)
			begin
				check(alarm, 1'b1);
				alarm_reset = 1'b1;
				step(1);
				alarm_reset = 1'b0;
				step(2);
				check(alarm, 1'b0);
			end
		end
		// Outage of one minute, then one phase back
		rand_cfg(cl_cfg, 3, 10'h002);
		load = 2'h0;
		step(595);
		check(cold_load, 1'b0);
		wait_lvl(cold_load, 1'b1, 60, n);
		check(cold_load, 1'b1);
		step(2);
		check(pickup, exp_pick(cl_cfg.raise_pct));
		check(group, exp_group(cl_cfg.group_sel));
		load = 2'h3;
		step(30);
		check(cold_load, 1'b1);
		phase_sel = 2'($urandom_range(2));
		load = 2'h1;
		wait_lvl(cold_load, 1'b0, 40, n);
		check(n >= 19 && n <= 33, 1'b1);
		// Both schemes at once
		load = 2'h2;
		rand_cfg(cl_cfg, 3, 10'h002);
		rand_cfg(mc_cfg, 3, 10'h002);
		for (int i = 0; i < 5; i++)
			mx[i] = cl_cfg.raise_pct[i] > mc_cfg.raise_pct[i] ? cl_cfg.raise_pct[i] : mc_cfg.raise_pct[i];
		cold_pin = 1'b1;
		close_req = 1'b1;
		step(1);
		close_req = 1'b0;
		step(8);
		check(inst_block, cl_cfg.inst_block_en | mc_cfg.inst_block_en);
		check(pickup, exp_pick(mx));
		// Manual close choice first, else the cold load choice
		check(group, (mc_cfg.group_sel >= 3'h1 && mc_cfg.group_sel <= 3'h4)
			? exp_group(mc_cfg.group_sel) : exp_group(cl_cfg.group_sel));
		cold_pin = 1'b0;
		step(40);
		stop_test();
	end
endmodule
